// File: logic/swve_device.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
// How it works
// - Master loads both target address bytes first
// - Status byte read-only, changed only internally
// - Status low five bits: last written offset
// - Bit 5 set on partial write byte
// - Bit 6 set on scratchpad overrun
// - Low address bits give start offset
// - Top status bit means copy accepted
// - Write clears accepted, partial, overrun flags
// - Write command: address low, high, data
// - Ending offset is where writing stopped
// - Read sends address, address, status first
// - Scratchpad read to end, then ones
// - Master retries on flagged read-back
// - Accepted flag still set: write proceeds, clears it
// - Master verifies read-back before copying
// - Copy needs address and status echoed
// - Memory read increments, ones past end
// - Regular speed unless placed in fast
// - Regular reset drops fast mode
// - Match sets accepted; reset ignored copying
// - After copy, zeros until reset
// - All bytes least significant bit first
module swve_device (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset, high
    swve_link_if.device link, // Single-wire link
    input wire logic od_enter, // Pulse: enter fast speed
    output logic fast_speed_select, // Fast speed active
    output logic copy_busy, // Copy in progress
    output logic cmd_error // Unknown command seen
);
    import swve_pkg::*;
    swve_dev_state_t state;
    logic [7:0] sp [0:SWVE_SP_BYTES-1];
    logic [7:0] mem [0:SWVE_MEM_BYTES-1];
    logic [7:0] target_address_low, target_address_high;
    logic [7:0] end_offset_status;
    logic [7:0] rx, tx, rx_next, sp_byte, auth_ref;
    logic [2:0] bitn;
    logic [5:0] k, k_next;
    logic [4:0] off, cp_off;
    logic full, is_write, auth, cp_done, byte_done;
    logic [15:0] maddr, maddr_next;
    logic [8:0] copy_cnt;
    logic [6:0] sp_idx;
    // ****************************************
    // Bit framing
    // ****************************************
    assign rx_next = {link.line_bit, rx[7:1]};
    assign byte_done = link.slot && (bitn == 3'h7);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bitn <= 3'h0;
            rx <= 8'h00;
        end else if (link.bus_reset && state != SWVE_COPY) begin
            bitn <= 3'h0;
        end else if (link.slot) begin
            bitn <= bitn + 3'h1;
            rx <= rx_next;
        end
    end
    // ****************************************
    // Next byte to send
    // ****************************************
    always_comb begin
        k_next = (k == 6'h3f) ? k : k + 6'h1;
        sp_idx = 7'({2'h0, target_address_low[4:0]}) + 7'({1'b0, k_next})
            - 7'h03;
        if (k_next == 6'h1) begin
            sp_byte = target_address_high;
        end else if (k_next == 6'h2) begin
            sp_byte = end_offset_status;
        end else if (sp_idx > 7'h1f) begin
            sp_byte = SWVE_ONES;
        end else begin
            sp_byte = sp[sp_idx[4:0]];
        end
        maddr_next = (maddr == 16'hffff) ? maddr : maddr + 16'h1;
        unique case (k[1:0])
            2'h0: auth_ref = target_address_low;
            2'h1: auth_ref = target_address_high;
            default: auth_ref = end_offset_status;
        endcase
    end
    // ****************************************
    // Speed select
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fast_speed_select <= 1'b0;
        end else if (link.bus_reset && state != SWVE_COPY
                && !link.reset_fast) begin
            fast_speed_select <= 1'b0;
        end else if (od_enter) begin
            fast_speed_select <= 1'b1;
        end
    end
    // ****************************************
    // Command sequencer
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= SWVE_CMD;
            target_address_low <= SWVE_TA_RST;
            target_address_high <= SWVE_TA_RST;
            end_offset_status <= SWVE_ES_RST;
            link.d_bit <= 1'b1;
            tx <= SWVE_ONES;
            k <= 6'h0;
            off <= 5'h0;
            full <= 1'b0;
            is_write <= 1'b0;
            auth <= 1'b0;
            maddr <= 16'h0;
            copy_cnt <= 9'h0;
            cmd_error <= 1'b0;
        end else if (link.bus_reset && state != SWVE_COPY) begin
            state <= SWVE_CMD;
            link.d_bit <= 1'b1;
            cmd_error <= 1'b0;
            if (state == SWVE_WR_DATA && bitn != 3'h0 && !full) begin
                end_offset_status[SWVE_PF_BIT] <= 1'b1;
            end
        end else begin
            unique case (state)
                SWVE_CMD: if (byte_done) begin
                    unique case (rx_next)
                        SWVE_CMD_WRITE_SP: begin
                            state <= SWVE_ADDR_LO;
                            is_write <= 1'b1;
                        end
                        SWVE_CMD_READ_MEM: begin
                            state <= SWVE_ADDR_LO;
                            is_write <= 1'b0;
                        end
                        SWVE_CMD_READ_SP: begin
                            state <= SWVE_RD_SP;
                            k <= 6'h0;
                            tx <= target_address_low;
                            link.d_bit <= target_address_low[0];
                        end
                        SWVE_CMD_COPY_SP: begin
                            state <= SWVE_AUTH;
                            k <= 6'h0;
                            auth <= 1'b1;
                        end
                        default: begin
                            state <= SWVE_IGNORE;
                            cmd_error <= 1'b1;
                        end
                    endcase
                end
                SWVE_ADDR_LO: if (byte_done) begin
                    target_address_low <= rx_next;
                    state <= SWVE_ADDR_HI;
                end
                SWVE_ADDR_HI: if (byte_done) begin
                    target_address_high <= rx_next;
                    if (is_write) begin
                        end_offset_status <=
                            {3'h0, target_address_low[4:0]};
                        off <= target_address_low[4:0];
                        full <= 1'b0;
                        state <= SWVE_WR_DATA;
                    end else begin
                        maddr <= {rx_next, target_address_low};
                        tx <= mem[{rx_next[4:0], target_address_low}];
                        link.d_bit <=
                            mem[{rx_next[4:0], target_address_low}][0];
                        if ({rx_next, target_address_low} > SWVE_MEM_LAST) begin
                            tx <= SWVE_ONES;
                            link.d_bit <= 1'b1;
                        end
                        state <= SWVE_RD_MEM;
                    end
                end
                SWVE_WR_DATA: begin
                    if (link.slot && full) begin
                        end_offset_status[SWVE_OF_BIT] <= 1'b1;
                    end else if (byte_done) begin
                        end_offset_status[4:0] <= off;
                        if (off == SWVE_SP_LAST) begin
                            full <= 1'b1;
                        end else begin
                            off <= off + 5'h1;
                        end
                    end
                end
                SWVE_RD_SP: if (link.slot) begin
                    if (bitn == 3'h7) begin
                        k <= k_next;
                        tx <= sp_byte;
                        link.d_bit <= sp_byte[0];
                    end else begin
                        link.d_bit <= tx[bitn + 3'h1];
                    end
                end
                SWVE_RD_MEM: if (link.slot) begin
                    if (bitn == 3'h7) begin
                        maddr <= maddr_next;
                        if (maddr_next > SWVE_MEM_LAST) begin
                            tx <= SWVE_ONES;
                            link.d_bit <= 1'b1;
                        end else begin
                            tx <= mem[maddr_next[12:0]];
                            link.d_bit <= mem[maddr_next[12:0]][0];
                        end
                    end else begin
                        link.d_bit <= tx[bitn + 3'h1];
                    end
                end
                SWVE_AUTH: if (byte_done) begin
                    k <= k + 6'h1;
                    if (k == 6'h2) begin
                        if (auth && rx_next == auth_ref) begin
                            end_offset_status[SWVE_AA_BIT] <= 1'b1;
                            copy_cnt <= 9'(SWVE_COPY_CYC);
                            state <= SWVE_COPY;
                        end else begin
                            state <= SWVE_IGNORE;
                        end
                    end else if (rx_next != auth_ref) begin
                        auth <= 1'b0;
                    end
                end
                SWVE_COPY: begin
                    copy_cnt <= copy_cnt - 9'h1;
                    if (copy_cnt == 9'h1) begin
                        state <= SWVE_DONE0;
                        link.d_bit <= 1'b0;
                    end
                end
                SWVE_DONE0: link.d_bit <= 1'b0;
                SWVE_IGNORE: link.d_bit <= 1'b1;
            endcase
        end
    end
    // ****************************************
    // Scratchpad store and copy to memory
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (state == SWVE_WR_DATA && byte_done && !full) begin
            sp[off] <= rx_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cp_off <= 5'h0;
            cp_done <= 1'b1;
            copy_busy <= 1'b0;
        end else begin
            copy_busy <= (state == SWVE_COPY);
            if (state == SWVE_AUTH) begin
                cp_off <= target_address_low[4:0];
                cp_done <= 1'b0;
            end else if (state == SWVE_COPY && !cp_done) begin
                cp_off <= cp_off + 5'h1;
                cp_done <= (cp_off == end_offset_status[4:0]);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (state == SWVE_COPY && !cp_done) begin
            mem[{target_address_high[4:0], target_address_low[7:5], cp_off}]
                <= sp[cp_off];
        end
    end
endmodule // swve_device

// File: logic/swve_pkg.sv
package swve_pkg;
    // ****************************************
    // Storage sizes and command codes
    // ****************************************
    localparam int SWVE_SP_BYTES = 32;
    localparam int SWVE_MEM_BYTES = 8192;
    localparam logic [4:0] SWVE_SP_LAST = 5'h1f;
    localparam logic [15:0] SWVE_MEM_LAST = 16'h1fff;
    localparam logic [7:0] SWVE_CMD_WRITE_SP = 8'h0f;
    localparam logic [7:0] SWVE_CMD_READ_SP = 8'haa;
    localparam logic [7:0] SWVE_CMD_COPY_SP = 8'h55;
    localparam logic [7:0] SWVE_CMD_READ_MEM = 8'hf0;

    // ****************************************
    // Status byte layout and reset values
    // ****************************************
    localparam int SWVE_PF_BIT = 5;
    localparam int SWVE_OF_BIT = 6;
    localparam int SWVE_AA_BIT = 7;
    localparam logic [7:0] SWVE_ES_RST = 8'h00;
    localparam logic [7:0] SWVE_TA_RST = 8'h00;
    localparam logic [7:0] SWVE_ONES = 8'hff;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SWVE_CLK_NS = 100;
    localparam int SWVE_COPY_NS = 30000;
    localparam int SWVE_COPY_CYC =
        (SWVE_COPY_NS + SWVE_CLK_NS - 1) / SWVE_CLK_NS;
    localparam int SWVE_SLOT_REG_NS = 61350;
    localparam int SWVE_SLOT_REG_CYC =
        (SWVE_SLOT_REG_NS + SWVE_CLK_NS - 1) / SWVE_CLK_NS;
    localparam int SWVE_SLOT_OD_NS = 7042;
    localparam int SWVE_SLOT_OD_CYC =
        (SWVE_SLOT_OD_NS + SWVE_CLK_NS - 1) / SWVE_CLK_NS;
    localparam int SWVE_RST_REG_NS = 480000;
    localparam int SWVE_RST_REG_CYC =
        (SWVE_RST_REG_NS + SWVE_CLK_NS - 1) / SWVE_CLK_NS;
    localparam int SWVE_RST_OD_NS = 48000;
    localparam int SWVE_RST_OD_CYC =
        (SWVE_RST_OD_NS + SWVE_CLK_NS - 1) / SWVE_CLK_NS;

    // ****************************************
    // Controller registers on APB
    // ****************************************
    localparam logic [7:0] SWVE_REG_CMD = 8'h00;
    localparam logic [7:0] SWVE_REG_TX = 8'h04;
    localparam logic [7:0] SWVE_REG_RX = 8'h08;
    localparam logic [7:0] SWVE_REG_STATUS = 8'h0c;
    localparam int SWVE_CMD_FAST_BIT = 2;
    localparam int SWVE_CMD_NBITS_LSB = 8;
    localparam logic [1:0] SWVE_OP_RESET = 2'h0;
    localparam logic [1:0] SWVE_OP_WRITE = 2'h1;
    localparam logic [1:0] SWVE_OP_READ = 2'h2;

    typedef enum logic [3:0] {
        SWVE_CMD, SWVE_ADDR_LO, SWVE_ADDR_HI, SWVE_WR_DATA, SWVE_RD_SP,
        SWVE_AUTH, SWVE_COPY, SWVE_DONE0, SWVE_RD_MEM, SWVE_IGNORE
    } swve_dev_state_t;

    typedef enum logic [1:0] {
        SWVE_M_IDLE, SWVE_M_RST, SWVE_M_BIT
    } swve_mst_state_t;
endpackage

// File: logic/swve_link_if.sv
`timescale 1ns/1ps
interface swve_link_if;
    logic slot;
    logic m_bit;
    logic bus_reset;
    logic reset_fast;
    logic d_bit;
    logic line_bit;

    // Wired-AND of the single data line
    assign line_bit = m_bit & d_bit;

    modport master (
        output slot, m_bit, bus_reset, reset_fast,
        input line_bit
    );
    modport device (
        input slot, bus_reset, reset_fast, line_bit,
        output d_bit
    );
endinterface

// File: logic/swve_master.sv
`timescale 1ns/1ps
module swve_master #(
    parameter int RST_REG_CYC = swve_pkg::SWVE_RST_REG_CYC // Regular reset
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset, high
    swve_link_if.master link, // Single-wire link
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr // APB error, unmapped address
);
    import swve_pkg::*;

    swve_mst_state_t state;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [7:0] shift;
    logic [2:0] bits_left;
    logic is_read;
    logic fast;
    logic [12:0] timer;
    logic [12:0] slot_len;
    logic wr_go;
    logic mapped;

    assign wr_go = psel && penable && pready && pwrite;
    assign mapped = (paddr == SWVE_REG_CMD) || (paddr == SWVE_REG_TX)
        || (paddr == SWVE_REG_RX) || (paddr == SWVE_REG_STATUS);
    assign slot_len = fast ? 13'(SWVE_SLOT_OD_CYC) : 13'(SWVE_SLOT_REG_CYC);

    // ****************************************
    // APB slave, one wait state
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (psel && penable && !pready) begin
                unique case (paddr)
                    SWVE_REG_TX: prdata <= {24'h0, tx_data};
                    SWVE_REG_RX: prdata <= {24'h0, rx_data};
                    SWVE_REG_STATUS:
                        prdata <= {30'h0, fast, state != SWVE_M_IDLE};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_data <= 8'h00;
        end else if (wr_go && paddr == SWVE_REG_TX) begin
            tx_data <= pwdata[7:0];
        end
    end

    // ****************************************
    // Link engine
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= SWVE_M_IDLE;
            link.slot <= 1'b0;
            link.m_bit <= 1'b1;
            link.bus_reset <= 1'b0;
            link.reset_fast <= 1'b0;
            shift <= 8'h00;
            rx_data <= 8'h00;
            bits_left <= 3'h0;
            is_read <= 1'b0;
            fast <= 1'b0;
            timer <= 13'h0;
        end else begin
            link.slot <= 1'b0;
            link.bus_reset <= 1'b0;
            unique case (state)
                SWVE_M_IDLE: if (wr_go && paddr == SWVE_REG_CMD) begin
                    fast <= pwdata[SWVE_CMD_FAST_BIT];
                    if (pwdata[1:0] == SWVE_OP_RESET) begin
                        // Reset timing picks the link speed
                        link.reset_fast <= pwdata[SWVE_CMD_FAST_BIT];
                        timer <= pwdata[SWVE_CMD_FAST_BIT]
                            ? 13'(SWVE_RST_OD_CYC) : 13'(RST_REG_CYC);
                        state <= SWVE_M_RST;
                    end else if (pwdata[1:0] == SWVE_OP_WRITE
                            || pwdata[1:0] == SWVE_OP_READ) begin
                        is_read <= pwdata[1:0] == SWVE_OP_READ;
                        bits_left <= pwdata[SWVE_CMD_NBITS_LSB +: 3];
                        shift <= tx_data;
                        link.m_bit <= (pwdata[1:0] == SWVE_OP_READ)
                            | tx_data[0];
                        timer <= pwdata[SWVE_CMD_FAST_BIT]
                            ? 13'(SWVE_SLOT_OD_CYC) : 13'(SWVE_SLOT_REG_CYC);
                        state <= SWVE_M_BIT;
                    end
                end
                SWVE_M_RST: begin
                    timer <= timer - 13'h1;
                    if (timer == 13'h1) begin
                        link.bus_reset <= 1'b1;
                        state <= SWVE_M_IDLE;
                    end
                end
                SWVE_M_BIT: begin
                    if (link.slot) begin
                        rx_data <= {link.line_bit, rx_data[7:1]};
                        shift <= {1'b1, shift[7:1]};
                        bits_left <= bits_left - 3'h1;
                        timer <= slot_len;
                        link.m_bit <= is_read | shift[1];
                        if (bits_left == 3'h0) begin
                            link.m_bit <= 1'b1;
                            state <= SWVE_M_IDLE;
                        end
                    end else if (timer == 13'h1) begin
                        link.slot <= 1'b1;
                    end else begin
                        timer <= timer - 13'h1;
                    end
                end
                default: state <= SWVE_M_IDLE;
            endcase
        end
    end
endmodule // swve_master

// File: test/swve_link_sva.sv
`timescale 1ns/1ps
module swve_link_sva (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic slot, // Bit slot pulse
    input wire logic m_bit, // Master bit
    input wire logic bus_reset, // Reset pulse ended
    input wire logic reset_fast, // Reset at fast timing
    input wire logic d_bit, // Device bit
    input wire logic line_bit // Wired-AND line
);
    // ****************************************
    // Link checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_quiet;
        !slot[*8];
    endsequence
    property p_slot_gap;
        slot |=> s_quiet;
    endproperty
    a_slot_gap: assert property (p_slot_gap)
        else $error("bit slots too close");
    property p_rst_gap;
        bus_reset |=> s_quiet;
    endproperty
    a_rst_gap: assert property (p_rst_gap)
        else $error("slot right after reset");
    property p_no_overlap;
        !(slot && bus_reset);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("slot and reset together");
    property p_mbit_hold;
        slot |-> $stable(m_bit) && (m_bit == $past(m_bit, 8));
    endproperty
    a_mbit_hold: assert property (p_mbit_hold)
        else $error("master bit moved between slots");
    property p_wired_and;
        line_bit == (m_bit & d_bit);
    endproperty
    a_wired_and: assert property (p_wired_and)
        else $error("line level wrong");
    property p_release;
        bus_reset |=> d_bit[*8];
    endproperty
    a_release: assert property (p_release)
        else $error("device holds line after reset");
    property p_rise_on_edge;
        $rose(d_bit) |-> $past(slot) || $past(bus_reset);
    endproperty
    a_rise_on_edge: assert property (p_rise_on_edge)
        else $error("device bit rose outside a slot");
    property p_fast_valid;
        bus_reset |-> $stable(reset_fast);
    endproperty
    a_fast_valid: assert property (p_fast_valid)
        else $error("reset speed moved at reset");
endmodule // swve_link_sva

// File: test/tb_scratchpad_write_verify_engine.sv
`timescale 1ns/1ps
module tb_scratchpad_write_verify_engine;
    import swve_pkg::*;
    // ****************************************
    // Bench
    // ****************************************
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, e;
    logic od_enter, fast_speed_select, copy_busy, cmd_error;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int fail_count, comparisons, cycles;
    // Row: 0 fast reset, 4 regular reset, 1 byte write, 3 three-bit write,
    // 2 byte read and compare, 5 read only, 7 copy probe, f pause
    logic [11:0] rows [$] = {12'h000, 12'h10f, 12'h126, 12'h100, 12'h1a5,
        12'h15a, 12'h000, 12'h1aa, 12'h226, 12'h200, 12'h207, 12'h2a5,
        12'h25a, 12'h000, 12'h155, 12'h126, 12'h100, 12'h107, 12'h400,
        12'h700, 12'hf00, 12'h200, 12'h000, 12'h1aa, 12'h226, 12'h200,
        12'h287, 12'h000, 12'h1f0, 12'h126, 12'h100, 12'h2a5, 12'h25a,
        12'h000, 12'h10f, 12'h13e, 12'h101, 12'h111, 12'h122, 12'h133,
        12'h000, 12'h1aa, 12'h23e, 12'h201, 12'h25f, 12'h211, 12'h222,
        12'h2ff, 12'h000, 12'h10f, 12'h100, 12'h100, 12'h305, 12'h000,
        12'h1aa, 12'h200, 12'h200, 12'h220, 12'h000, 12'h1f0, 12'h1ff,
        12'h11f, 12'h500, 12'h2ff, 12'h000, 12'h133, 12'h2ff};
    swve_link_if lnk();
    swve_master #(.RST_REG_CYC(10)) i_swve_master (.clk_sys(clk_sys),
        .rst(rst), .link(lnk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    swve_device i_swve_device (.clk_sys(clk_sys), .rst(rst), .link(lnk),
        .od_enter(od_enter), .fast_speed_select(fast_speed_select),
        .copy_busy(copy_busy), .cmd_error(cmd_error));
    swve_link_sva i_swve_link_sva (.clk_sys(clk_sys), .rst(rst),
        .slot(lnk.slot), .m_bit(lnk.m_bit), .bus_reset(lnk.bus_reset),
        .reset_fast(lnk.reset_fast), .d_bit(lnk.d_bit),
        .line_bit(lnk.line_bit));
    task automatic chk(input string n, input logic [7:0] s, x);
        comparisons++;
        if (s !== x) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic op(input logic [10:0] c);
        apb(1'b1, SWVE_REG_CMD, 32'(c));
        apb(1'b0, SWVE_REG_STATUS, 32'h0);
        while (q[0] !== 1'b0) apb(1'b0, SWVE_REG_STATUS, 32'h0);
    endtask
    task automatic row(input logic [11:0] r);
        case (r[11:8])
            4'h0: op(11'h004);
            4'h4: op(11'h000);
            4'h1, 4'h3: begin
                apb(1'b1, SWVE_REG_TX, 32'(r[7:0]));
                op(r[9] ? 11'h205 : 11'h705);
            end
            4'h7: begin
                chk("copy_busy", 8'(copy_busy), 8'h1);
                chk("fast_copy", 8'(fast_speed_select), 8'h1);
            end
            4'hf: repeat (400) @(posedge clk_sys);
            default: begin
                op(11'h706);
                apb(1'b0, SWVE_REG_RX, 32'h0);
                if (r[11:8] == 4'h2) chk("rx", q[7:0], r[7:0]);
            end
        endcase
    endtask
    task automatic summarize();
        if (fail_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        {rst, psel, penable, pwrite, od_enter} = 5'h10;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk("fast_rst", 8'(fast_speed_select), 8'h0);
        od_enter <= 1'b1;
        @(posedge clk_sys);
        od_enter <= 1'b0;
        @(posedge clk_sys);
        @(posedge clk_sys);
        chk("fast_on", 8'(fast_speed_select), 8'h1);
        foreach (rows[i]) row(rows[i]);
        chk("cmd_error", 8'(cmd_error), 8'h1);
        chk("fast_kept", 8'(fast_speed_select), 8'h1);
        row(12'h400);
        chk("cmd_clear", 8'(cmd_error), 8'h0);
        chk("fast_off", 8'(fast_speed_select), 8'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped_err", 8'(e), 8'h1);
        chk("unmapped_data", q[7:0], 8'h0);
        summarize();
    end
endmodule // tb_scratchpad_write_verify_engine
